// *** core/adcs_defs.svh ***
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// ----------------------------------------
// register addresses on the special-function bus
// ----------------------------------------
`define ADCS_CTRL_ADDR 8'hD8
`define ADCS_START_ADDR 8'hDA
`define ADCS_RESULT_ADDR 8'hD9
`define ADCS_IRQ_ADDR 8'hC0
// ----------------------------------------
// control and flag register fields, reset values
// ----------------------------------------
`define ADCS_CH_LSB 0
`define ADCS_CH_MSB 2
`define ADCS_MODE_BIT 3
`define ADCS_BUSY_BIT 4
`define ADCS_BAUD_BIT 7
`define ADCS_DONE_BIT 0
`define ADCS_CTRL_RESET 8'h00
`define ADCS_RSVD_VALUE 2'h0
`define ADCS_RESULT_RESET 8'h00
// ----------------------------------------
// timing: oscillator cycles per machine cycle, then lengths in machine cycles
// ----------------------------------------
`define ADCS_OSC_PER_MC 24
`define ADCS_CONV_MC 15
`define ADCS_SAMPLE_MC 5
`define ADCS_DONE_MC 11
`endif

// *** core/adcs_mc_strobe.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
// ----------------------------------------
// machine-cycle strobe divider
// ----------------------------------------
module adcs_mc_strobe (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one-cycle strobe
  output logic mc_tick
);
  logic [4:0] div; // oscillator cycles within a machine cycle
  // free running divider, strobe on wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 5'h00;
      mc_tick <= 1'b0;
    end else if (div == 5'(`ADCS_OSC_PER_MC - 1)) begin
      div <= 5'h00;
      mc_tick <= 1'b1;
    end else begin
      div <= div + 5'h01;
      mc_tick <= 1'b0;
    end
  end
endmodule // adcs_mc_strobe
`default_nettype wire

// *** core/adcs_pkg.sv ***
package adcs_pkg;
  // sequencer phases
  typedef enum logic [1:0] {
    ADCS_IDLE,
    ADCS_SAMPLE,
    ADCS_APPROX
  } adcs_state_e;
  typedef logic [7:0] adcs_byte_t;
endpackage

// *** core/adcs_seq.sv ***
// Operation
// - any start write triggers conversion
// - start reads leave conversion untouched
// - start while busy restarts conversion
// - conversion begins next machine cycle
// - busy set in write cycle
// - conversion lasts fifteen machine cycles
// - sample first five cycles, then hold
// - approximation in cycles six to fifteen
// - cycle fifteen stores result, clears busy in single mode
// - done flag set end cycle eleven
// - continuous mode restarts automatically
// - mode bit selects single or continuous
// - busy bit reads conversion state
// - three bits select one of eight
// - bit seven selects baud generator source
// - continuous mode sets done each conversion
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_seq
  import adcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // analog front end
  output logic [2:0] mux_sel,
  output logic sample_en,
  output logic sar_trial,
  input wire logic cmp_in,
  // serial channel
  output logic baud_source_select,
  // event flag
  output logic conversion_done_flag
);
  // ----------------------------------------
  // machine cycle strobe
  // ----------------------------------------
  logic mc_tick; // one clk wide per machine cycle
  adcs_mc_strobe u_tick (
    .clk(clk),
    .rst(rst),
    .mc_tick(mc_tick)
  );
  // comparator is analog, synchronise it
  logic cmp_s1;
  logic cmp_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      cmp_s1 <= cmp_in;
      cmp_s2 <= cmp_s1;
    end
  end
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_ctrl; // control register write
  logic wr_start; // start register write, data ignored
  logic wr_irq; // flag register write
  assign wr_ctrl = sfr_wr && (sfr_addr == `ADCS_CTRL_ADDR);
  assign wr_start = sfr_wr && (sfr_addr == `ADCS_START_ADDR);
  assign wr_irq = sfr_wr && (sfr_addr == `ADCS_IRQ_ADDR);
  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [2:0] channel_select; // channel select bits
  logic continuous_mode_bit; // repeat conversions
  logic conversion_in_progress_flag; // busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_select <= 3'h0;
      continuous_mode_bit <= 1'b0;
      baud_source_select <= 1'b0;
    end else if (wr_ctrl) begin
      // busy is hardware owned and reserved bits are dropped
      channel_select <= sfr_wdata[`ADCS_CH_MSB:`ADCS_CH_LSB];
      continuous_mode_bit <= sfr_wdata[`ADCS_MODE_BIT];
      baud_source_select <= sfr_wdata[`ADCS_BAUD_BIT];
    end
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  adcs_state_e state; // phase of conversion
  logic [3:0] mc_cnt; // machine cycle number within conversion, 1..15
  logic pending; // start written, waiting for next machine cycle
  logic [7:0] sar; // approximation register
  logic [7:0] trial_bit; // bit currently under trial
  logic [7:0] result; // finished code
  logic last_mc; // final machine cycle boundary
  logic [2:0] held_ch; // channel latched at start
  assign last_mc = mc_tick && (state != ADCS_IDLE) && (mc_cnt == 4'(`ADCS_CONV_MC));
  // pending start; a write inside the current machine cycle waits for the next
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (wr_start) begin
      pending <= 1'b1;
    end else if (mc_tick) begin
      pending <= 1'b0;
    end
  end
  // phase and cycle counter, all advancing on the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ADCS_IDLE;
      mc_cnt <= 4'h0;
      held_ch <= 3'h0;
    end else if (mc_tick) begin
      if (pending && !wr_start) begin
        // fresh start abandons any conversion in flight
        state <= ADCS_SAMPLE;
        mc_cnt <= 4'h1;
        held_ch <= channel_select;
      end else if (last_mc) begin
        if (continuous_mode_bit) begin
          state <= ADCS_SAMPLE;
          mc_cnt <= 4'h1;
          held_ch <= channel_select;
        end else begin
          state <= ADCS_IDLE;
          mc_cnt <= 4'h0;
        end
      end else if (state != ADCS_IDLE) begin
        mc_cnt <= mc_cnt + 4'h1;
        unique case (state)
          ADCS_SAMPLE: begin
            if (mc_cnt == 4'(`ADCS_SAMPLE_MC)) begin
              state <= ADCS_APPROX;
            end
          end
          ADCS_APPROX: begin
            state <= ADCS_APPROX;
          end
          ADCS_IDLE: begin
            state <= ADCS_IDLE;
          end
        endcase
      end
    end
  end
  // busy flag, set in the write cycle itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_in_progress_flag <= 1'b0;
    end else if (wr_start) begin
      conversion_in_progress_flag <= 1'b1;
    end else if (last_mc && !pending && !continuous_mode_bit) begin
      conversion_in_progress_flag <= 1'b0;
    end
  end
  // successive approximation: one trial per cycle in cycles six to thirteen, msb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sar <= 8'h00;
      trial_bit <= 8'h00;
    end else if (mc_tick) begin
      if (state == ADCS_SAMPLE && mc_cnt == 4'(`ADCS_SAMPLE_MC)) begin
        sar <= 8'h80;
        trial_bit <= 8'h80;
      end else if (state == ADCS_APPROX && trial_bit != 8'h00) begin
        // keep the trial bit if comparator says input is above the dac
        sar <= (cmp_s2 ? sar : (sar & ~trial_bit)) | (trial_bit >> 1);
        trial_bit <= trial_bit >> 1;
      end
    end
  end
  // result register loaded at the close of cycle fifteen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= `ADCS_RESULT_RESET;
    end else if (last_mc && !pending) begin
      result <= sar;
    end
  end
  // done flag: set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (mc_tick && state == ADCS_APPROX && mc_cnt == 4'(`ADCS_DONE_MC)) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_irq && !sfr_wdata[`ADCS_DONE_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end
  // ----------------------------------------
  // analog front end drive
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_sel <= 3'h0;
      sample_en <= 1'b0;
      sar_trial <= 1'b0;
    end else begin
      mux_sel <= held_ch;
      sample_en <= (state == ADCS_SAMPLE);
      sar_trial <= (state == ADCS_APPROX);
    end
  end
  // ----------------------------------------
  // read data; the start register reads zero and has no side effect
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `ADCS_CTRL_ADDR: sfr_rdata <= {baud_source_select, `ADCS_RSVD_VALUE,
          conversion_in_progress_flag, continuous_mode_bit, channel_select};
        `ADCS_RESULT_ADDR: sfr_rdata <= result;
        `ADCS_IRQ_ADDR: sfr_rdata <= {7'h00, conversion_done_flag};
        `ADCS_START_ADDR: sfr_rdata <= 8'h00;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // busy must show on the edge after the start write
  busy_on_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_start |=> conversion_in_progress_flag) else $error("busy not set on start");
  // a pending start is taken on the very next strobe
  start_next_mc_a: assert property (@(posedge clk) disable iff (rst)
    (mc_tick && pending && !wr_start) |=> (state == ADCS_SAMPLE && mc_cnt == 4'h1))
    else $error("start not taken");
  // sampling ends after cycle five unless a restart intervenes
  sample_len_a: assert property (@(posedge clk) disable iff (rst)
    (mc_tick && state == ADCS_SAMPLE && mc_cnt == 4'h5 && !pending) |=> state == ADCS_APPROX)
    else $error("sample phase length wrong");
  // counter never leaves the fifteen cycle window
  count_range_a: assert property (@(posedge clk) disable iff (rst)
    state != ADCS_IDLE |-> (mc_cnt >= 4'h1 && mc_cnt <= 4'hF))
    else $error("cycle count out of range");
  // done flag only rises out of cycle eleven
  done_at_eleven_a: assert property (@(posedge clk) disable iff (rst)
    $rose(conversion_done_flag) |-> $past(mc_cnt) == 4'hB)
    else $error("done flag at wrong cycle");
  // result takes the finished code at the close of cycle fifteen
  result_store_a: assert property (@(posedge clk) disable iff (rst)
    (last_mc && !pending) |=> result == $past(sar))
    else $error("result not stored");
  // single mode parks the sequencer after one conversion
  single_stop_a: assert property (@(posedge clk) disable iff (rst)
    (last_mc && !pending && !continuous_mode_bit && !wr_start) |=> state == ADCS_IDLE)
    else $error("single mode did not stop");
  // continuous mode chains straight into the next conversion
  cont_restart_a: assert property (@(posedge clk) disable iff (rst)
    (last_mc && continuous_mode_bit) |=> (state == ADCS_SAMPLE && mc_cnt == 4'h1))
    else $error("continuous restart missing");
  // reading the start register must not arm a start
  start_read_a: assert property (@(posedge clk) disable iff (rst)
    (sfr_rd && !sfr_wr && sfr_addr == `ADCS_START_ADDR) |=> !$rose(pending))
    else $error("start read disturbed sequencer");
  // the strobe keeps a fixed machine cycle length
  tick_period_a: assert property (@(posedge clk) disable iff (rst)
    mc_tick |-> ##24 mc_tick)
    else $error("machine strobe period wrong");
  // busy drops at the close of a single conversion
  busy_clear_a: assert property (@(posedge clk) disable iff (rst)
    (last_mc && !pending && !continuous_mode_bit && !wr_start) |=> !conversion_in_progress_flag)
    else $error("busy not cleared at end");
  // done flag raised on the edge that ends cycle eleven
  done_set_a: assert property (@(posedge clk) disable iff (rst)
    (mc_tick && state == ADCS_APPROX && mc_cnt == 4'(`ADCS_DONE_MC)) |=> conversion_done_flag)
    else $error("done flag not set");
  // done flag stays up until software writes a zero
  done_hold_a: assert property (@(posedge clk) disable iff (rst)
    (conversion_done_flag && !(wr_irq && !sfr_wdata[`ADCS_DONE_BIT])) |=> conversion_done_flag)
    else $error("done flag lost");
  // sample output trails the sample phase by one clock
  sample_out_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (sample_en == $past(state == ADCS_SAMPLE)))
    else $error("sample output wrong");
  // trial output trails the approximation phase by one clock
  trial_out_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (sar_trial == $past(state == ADCS_APPROX)))
    else $error("trial output wrong");
  // channel output follows the channel latched at start
  chan_out_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (mux_sel == $past(held_ch)))
    else $error("channel output wrong");
  // baud source bit follows a control write
  baud_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> (baud_source_select == $past(sfr_wdata[`ADCS_BAUD_BIT])))
    else $error("baud source not written");
  // reserved bits always read the fixed value
  rsvd_read_a: assert property (@(posedge clk) disable iff (rst)
    (sfr_rd && sfr_addr == `ADCS_CTRL_ADDR)
    |=> (sfr_rdata[`ADCS_BAUD_BIT-1:`ADCS_BUSY_BIT+1] == `ADCS_RSVD_VALUE))
    else $error("reserved bits read wrong");
  // busy bit on a read mirrors the live flag
  busy_read_a: assert property (@(posedge clk) disable iff (rst)
    (sfr_rd && sfr_addr == `ADCS_CTRL_ADDR)
    |=> (sfr_rdata[`ADCS_BUSY_BIT] == $past(conversion_in_progress_flag)))
    else $error("busy bit read wrong");
  // start register reads back as zero
  start_zero_a: assert property (@(posedge clk) disable iff (rst)
    (sfr_rd && sfr_addr == `ADCS_START_ADDR) |=> (sfr_rdata == 8'h00))
    else $error("start register read not zero");
endmodule // adcs_seq
`default_nettype wire

// *** sim/adcs_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
// ----------------------------------------
// cpu core stand-in on the register bus
// ----------------------------------------
module adcs_cpu_model (
  // clock
  input wire logic clk,
  // register bus toward the sequencer
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd,
  input wire logic [7:0] sfr_rdata
);
  // bus idle from time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // one write; released lines go inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask
  // one read; data is taken a full cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    @(negedge clk);
    d = sfr_rdata;
  endtask
  // software has to clear the done flag itself
  task automatic clear_done();
    wr(`ADCS_IRQ_ADDR, 8'h00);
  endtask
endmodule // adcs_cpu_model
`default_nettype wire

// *** sim/tb_adc_conversion_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcs_defs.svh"
module tb_adc_conversion_sequencer
  import adcs_pkg::*;
();
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {adcs_byte_t ctrl; logic cmp; adcs_byte_t exp_ctrl; adcs_byte_t exp_res;}
    adcs_row_s;
  // reserved and busy bits are written 1 but must read back 0
  adcs_row_s rows [8] = '{'{8'h70, 1'b0, 8'h00, 8'h00}, '{8'hF1, 1'b0, 8'h81, 8'h00},
    '{8'h72, 1'b1, 8'h02, 8'hFF}, '{8'hF3, 1'b1, 8'h83, 8'hFF}, '{8'h74, 1'b0, 8'h04, 8'h00},
    '{8'hF5, 1'b0, 8'h85, 8'h00}, '{8'h76, 1'b1, 8'h06, 8'hFF}, '{8'hF7, 1'b1, 8'h87, 8'hFF}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmp_in = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic sfr_wr, sfr_rd, sample_en, sar_trial, baud_source_select, conversion_done_flag;
  logic [2:0] mux_sel;
  logic done_q = 1'b0;
  logic smp_q = 1'b0;
  int cyc, t_wr, t_done, t_smp, t0, run_s, run_a, len_s, len_a, n_errors, n_tests;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  adcs_seq DUT (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .mux_sel,
    .sample_en, .sar_trial, .cmp_in, .baud_source_select, .conversion_done_flag);
  adcs_cpu_model cpu (.clk, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata);
  // ----------------------------------------
  // phase monitor: run lengths and edge times
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    done_q <= conversion_done_flag;
    smp_q <= sample_en;
    run_s <= sample_en ? run_s + 1 : 0;
    run_a <= sar_trial ? run_a + 1 : 0;
    if (!sample_en && run_s != 0) len_s <= run_s;
    if (!sar_trial && run_a != 0) len_a <= run_a;
    if (conversion_done_flag && !done_q) t_done <= cyc;
    if (sample_en && !smp_q) t_smp <= cyc;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the done flag; a hang counts as a mismatch
  task automatic wait_done();
    int k;
    for (k = 0; k < 800 && conversion_done_flag !== 1'b1; k++) @(negedge clk);
    if (k == 800) begin
      n_errors++;
      conclude();
    end
    // the monitor logs the rising edge one clock later
    @(negedge clk);
  endtask
  // start a conversion, note the cycle the write was taken
  task automatic start(input logic [7:0] d);
    cpu.wr(`ADCS_START_ADDR, d);
    t_wr = cyc - 1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    cpu.rd(`ADCS_CTRL_ADDR, v);
    chk("ctrl reset", v, 8'h00);
    // ordinary single conversions, one per channel
    foreach (rows[i]) begin
      cpu.wr(`ADCS_CTRL_ADDR, rows[i].ctrl);
      cmp_in = rows[i].cmp;
      start(8'(i * 37));
      cpu.rd(`ADCS_CTRL_ADDR, v);
      chk("busy", v[4], 1'b1);
      wait_done();
      chk("done delay", 32'(t_done - t_wr inside {[265:290]}), 1);
      chk("sample to done", 32'(t_done - t_smp inside {[263:265]}), 1);
      chk("channel", mux_sel, rows[i].exp_ctrl[2:0]);
      chk("baud", baud_source_select, rows[i].exp_ctrl[7]);
      cpu.rd(`ADCS_CTRL_ADDR, v);
      chk("busy at done", v[4], 1'b1);
      repeat (120) @(negedge clk);
      cpu.rd(`ADCS_RESULT_ADDR, v);
      chk("result", v, rows[i].exp_res);
      cpu.rd(`ADCS_CTRL_ADDR, v);
      chk("ctrl", v, rows[i].exp_ctrl);
      chk("sample len", len_s, 120);
      chk("approx len", len_a, 240);
      cpu.clear_done();
      chk("done cleared", conversion_done_flag, 1'b0);
    end
    // restart in mid-conversion, with a start read in between
    cpu.wr(`ADCS_CTRL_ADDR, 8'h01);
    cmp_in = 1'b1;
    start(8'hFF);
    repeat (200) @(negedge clk);
    cpu.rd(`ADCS_START_ADDR, v);
    chk("start read", v, 8'h00);
    chk("no early done", conversion_done_flag, 1'b0);
    // the fresh conversion sees a low comparator, unlike the last row
    cmp_in = 1'b0;
    start(8'h00);
    wait_done();
    chk("restart delay", 32'(t_done - t_wr inside {[265:290]}), 1);
    repeat (120) @(negedge clk);
    cpu.rd(`ADCS_RESULT_ADDR, v);
    chk("restart result", v, 8'h00);
    cpu.clear_done();
    // continuous mode: done each conversion, fifteen cycles apart
    cpu.wr(`ADCS_CTRL_ADDR, 8'h0A);
    cmp_in = 1'b0;
    start(8'h5A);
    wait_done();
    t0 = t_done;
    cpu.clear_done();
    wait_done();
    chk("period", t_done - t0, 360);
    chk("second done", conversion_done_flag, 1'b1);
    cpu.wr(`ADCS_CTRL_ADDR, 8'h02);
    repeat (400) @(negedge clk);
    cpu.rd(`ADCS_CTRL_ADDR, v);
    chk("stopped", v, 8'h02);
    cpu.clear_done();
    // reset in mid-run, then an unmapped read
    start(8'h11);
    repeat (50) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk("sample in reset", sample_en, 1'b0);
    rst = 1'b0;
    cpu.rd(`ADCS_CTRL_ADDR, v);
    chk("ctrl after reset", v, 8'h00);
    cpu.rd(8'h55, v);
    chk("unmapped", v, 8'h00);
    conclude();
  end
endmodule // tb_adc_conversion_sequencer
`default_nettype wire
